// ==== psr_flags.sv ====
// special relay flag bank: scan pulses, square waves and status flags
// assumes status and scan inputs come from core logic on core_clk_in
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module psr_flags #(
    parameter bit HAS_TRACE = 1'b1
) (
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_n_in,
    input  wire psr_pkg::psr_scan_t             scan_in,
    input  wire psr_pkg::psr_status_t           status_in,
    input  wire logic [psr_pkg::ADDR_W-1:0]     addr_in,
    input  wire logic [psr_pkg::DATA_W-1:0]     wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic      [psr_pkg::DATA_W-1:0]     rdata_out,
    output logic                                err_out
);
    // ****************************************************************
    // base tick generator
    // ****************************************************************
    localparam int unsigned BW = $clog2(psr_pkg::HALF_BASE_CYC);
    localparam logic [BW-1:0] BASE_LAST =
        BW'(psr_pkg::HALF_BASE_CYC - 1);
    logic [BW-1:0] base_cnt_r;
    wire           tick = (base_cnt_r == BASE_LAST);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= tick ? '0 : base_cnt_r + BW'(1);
        end
    end

    // ****************************************************************
    // square waves, each its own tick divider
    // ****************************************************************
    logic [psr_pkg::NUM_WAVES-1:0] square_r;
    genvar gi;
    generate
        for (gi = 0; gi < psr_pkg::NUM_WAVES; gi++) begin : g_wave
            logic [psr_pkg::TICK_W-1:0] cnt_r;
            wire wrap = tick &&
                (cnt_r == psr_pkg::HALF_TICKS[gi] - 1'b1);
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    cnt_r       <= '0;
                    square_r[gi] <= 1'b1;
                end else if (tick) begin
                    cnt_r <= wrap ? '0 : cnt_r + 1'b1;
                    if (wrap) begin
                        square_r[gi] <= ~square_r[gi];
                    end
                end
            end
            // a wave may only move on its own wrap tick
            a_wave_hold: assert property (@(posedge core_clk_in)
                disable iff (!rst_n_in)
                !wrap |=> $stable(square_r[gi]))
                else $error("square wave moved off its tick");
            a_wave_flip: assert property (@(posedge core_clk_in)
                disable iff (!rst_n_in)
                wrap |=> square_r[gi] != $past(square_r[gi]))
                else $error("square wave missed its tick");
        end
    endgenerate
    // periods set by HALF_TICKS per wave

    // ****************************************************************
    // scan pulses
    // ****************************************************************
    psr_pkg::psr_run_t run_r;
    psr_pkg::psr_run_t run_nxt;
    logic scan_toggle_r;
    logic step_start_r;
    logic step_pending_r;

    always_comb begin
        run_nxt = run_r;
        case (run_r)
            psr_pkg::PSR_PROGRAMMING_POSITION: begin
                if (status_in.run_sel) begin
                    run_nxt = psr_pkg::PSR_FIRST;
                end
            end
            psr_pkg::PSR_FIRST: begin
                if (!status_in.run_sel) begin
                    run_nxt = psr_pkg::PSR_PROGRAMMING_POSITION;
                end else if (scan_in.scan_end) begin
                    run_nxt = psr_pkg::PSR_RUNNING;
                end
            end
            psr_pkg::PSR_RUNNING: begin
                if (!status_in.run_sel) begin
                    run_nxt = psr_pkg::PSR_PROGRAMMING_POSITION;
                end
            end
            default: run_nxt = psr_pkg::PSR_PROGRAMMING_POSITION;
        endcase
    end

    wire first_scan = (run_r == psr_pkg::PSR_FIRST);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r          <= psr_pkg::PSR_PROGRAMMING_POSITION;
            scan_toggle_r  <= 1'b0;
            step_start_r   <= 1'b0;
            step_pending_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            if (scan_in.scan_end) begin
                scan_toggle_r <= ~scan_toggle_r;
            end
            // a boot arms the pulse for the following scan only
            if (scan_in.scan_end) begin
                step_start_r   <= step_pending_r | scan_in.step_boot;
                step_pending_r <= 1'b0;
            end else if (scan_in.step_boot) begin
                step_pending_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    logic int_fault_r;
    logic trace_done_r;
    logic sampling_r;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_fault_r  <= 1'b0;
            trace_done_r <= 1'b0;
            sampling_r   <= 1'b0;
        end else begin
            if (status_in.int_error) begin
                int_fault_r <= 1'b1;
            end
            if (status_in.trace_start) begin
                trace_done_r <= 1'b0;
                sampling_r   <= 1'b1;
            end else if (status_in.trace_stop) begin
                trace_done_r <= 1'b1;
                sampling_r   <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // register read port, read only
    // ****************************************************************
    wire [3:0] trace_bits = HAS_TRACE ?
        {sampling_r, status_in.stop_trigger, trace_done_r,
         status_in.sample_timed} : 4'h0;

    wire [psr_pkg::DATA_W-1:0] word0 = {
        1'b0, square_r,                       // bits 14..8
        2'b00, step_start_r,
        ~first_scan & (run_r != psr_pkg::PSR_PROGRAMMING_POSITION),
        first_scan,
        scan_toggle_r, 1'b0, 1'b1};

    wire [psr_pkg::DATA_W-1:0] word1 = {
        trace_bits,
        int_fault_r, status_in.int_enabled,
        status_in.forcing, 2'b00,
        status_in.message_exec,
        5'h00, status_in.run_sel};

    wire hit0 = (addr_in == psr_pkg::OFS_WORD0);
    wire hit1 = (addr_in == psr_pkg::OFS_WORD1);
    wire [psr_pkg::DATA_W-1:0] rsel =
        hit0 ? word0 : (hit1 ? word1 : '0);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= '0;
            err_out   <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rsel : '0;
            // writes are ignored and flagged with the unmapped reads
            err_out   <= wr_in | (rd_in & ~(hit0 | hit1));
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_toggle_flip: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        scan_in.scan_end |=> scan_toggle_r != $past(scan_toggle_r))
        else $error("scan toggle did not flip");
    a_first_once: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (first_scan && scan_in.scan_end && status_in.run_sel)
        |=> !first_scan)
        else $error("first scan lasted past one scan");
    a_first_entry: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (run_r == psr_pkg::PSR_PROGRAMMING_POSITION && status_in.run_sel) |=> first_scan)
        else $error("run entry missed first scan");
    a_fast_wave: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (tick && g_wave[0].wrap) |=> square_r[0] != $past(square_r[0]))
        else $error("10 ms wave did not flip");
    a_base_tick: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        tick |=> !tick [*8])
        else $error("base tick too frequent");
    a_fault_sticky: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        status_in.int_error |=> int_fault_r [*3])
        else $error("interrupt fault not held");
    a_trace_pair: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        trace_done_r != sampling_r || (!trace_done_r && !sampling_r))
        else $error("trace flags both set");
    a_read_const: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit0) |=> rdata_out[1:0] == 2'b01)
        else $error("constant flags wrong");
    a_write_err: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        wr_in |=> err_out)
        else $error("write not refused");

    // ****************************************************************
    // checks on the base tick
    // ****************************************************************
    a_tick_restart: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        tick |=> base_cnt_r == '0)
        else $error("base counter did not restart");

    a_tick_count: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !tick |=> base_cnt_r == $past(base_cnt_r) + BW'(1))
        else $error("base counter skipped");

    // ****************************************************************
    // checks on the scan pulses
    // ****************************************************************
    a_step_pulse: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        scan_in.scan_end |=>
            step_start_r == $past(step_pending_r | scan_in.step_boot))
        else $error("step start pulse wrong at scan end");

    a_step_hold: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !scan_in.scan_end |=> $stable(step_start_r))
        else $error("step start changed inside a scan");

    a_first_low: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (run_r == psr_pkg::PSR_RUNNING) |-> word0[psr_pkg::B_FIRST_LOW])
        else $error("first scan low flag off in later scan");

    a_programming_position_exit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !status_in.run_sel |=> run_r == psr_pkg::PSR_PROGRAMMING_POSITION)
        else $error("run state kept after leaving run");

    // ****************************************************************
    // checks on the status word
    // ****************************************************************
    a_run_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1) |=>
            rdata_out[psr_pkg::B_RUN_STATE] == $past(status_in.run_sel))
        else $error("run state bit wrong");

    a_message_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1) |=>
            rdata_out[psr_pkg::B_MESSAGE] == $past(status_in.message_exec))
        else $error("message bit wrong");

    a_forcing_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1) |=>
            rdata_out[psr_pkg::B_FORCING] == $past(status_in.forcing))
        else $error("forcing bit wrong");

    a_int_en_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1) |=>
            rdata_out[psr_pkg::B_INT_EN] == $past(status_in.int_enabled))
        else $error("interrupt enabled bit wrong");

    a_sample_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1 && HAS_TRACE) |=>
            rdata_out[psr_pkg::B_SAMPLE_TIME] ==
                $past(status_in.sample_timed))
        else $error("sample timing bit wrong");

    a_stop_bit: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1 && HAS_TRACE) |=>
            rdata_out[psr_pkg::B_STOP_TRIG] ==
                $past(status_in.stop_trigger))
        else $error("stop trigger bit wrong");

    a_trace_small: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && hit1 && !HAS_TRACE) |=> rdata_out[15:12] == 4'h0)
        else $error("trace bits present in small variant");

    a_trace_start: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        status_in.trace_start |=> sampling_r && !trace_done_r)
        else $error("trace start not taken");

    a_trace_stop: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (status_in.trace_stop && !status_in.trace_start)
        |=> trace_done_r && !sampling_r)
        else $error("trace stop not taken");

    // ****************************************************************
    // checks on the read port
    // ****************************************************************
    a_idle_zero: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !rd_in |=> rdata_out == '0)
        else $error("read data without a read");

    a_unmapped_err: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rd_in && !hit0 && !hit1) |=> err_out && rdata_out == '0)
        else $error("unmapped read not refused");
endmodule

// ==== psr_pkg.sv ====
// package for the special relay flag bank: offsets, timing counts, carriers
// assumes one 25 MHz core clock and a plain register read port
// ****************************************************************
// What this block does
// - scan toggle flag inverts at every program scan
// - first-scan-high flag on only in first scan after run entry
// - first-scan-low flag off in first scan after run entry and while not in run
// - step start flag on only for first scan after a process boots
// - 10 ms square wave has full period 0.01 s
// - 20 ms square wave has full period 0.02 s
// - 100 ms square wave has full period 0.1 s
// - 200 ms square wave has full period 0.2 s
// - one-second square wave has full period 1 s
// - two-second square wave has full period 2 s
// - one-minute square wave has full period 1 min
// - run state flag follows the mode selector run position
// - message active flag is on while the message instruction runs
// - forcing active flag is on while any forcing is in effect
// - interrupt enabled flag on while external trigger is enabled
// - interrupt fault flag turns on when an interrupt error occurs
// - sample timing flag is 0 for instruction, 1 for timed sampling
// - trace finished is 1 after stop; sampling active 1 after start
// - stop trigger flag is 1 while the stop trigger is active
// - the four trace flags exist only in the 32k variant
// - all flags are read-only and drive no external output
// ****************************************************************
package psr_pkg;
    localparam int unsigned CLK_HZ        = 25000000;
    // square wave full periods in microseconds
    localparam int unsigned PER_10MS_US   = 10000;
    localparam int unsigned PER_20MS_US   = 20000;
    localparam int unsigned PER_100MS_US  = 100000;
    localparam int unsigned PER_200MS_US  = 200000;
    localparam int unsigned PER_1S_US     = 1000000;
    localparam int unsigned PER_2S_US     = 2000000;
    localparam int unsigned PER_1MIN_US   = 60000000;
    // 5 ms base tick: half period of the fastest wave is 5 ms
    localparam int unsigned HALF_BASE_US  = PER_10MS_US / 2;
    localparam int unsigned HALF_BASE_CYC =
        (CLK_HZ / 1000) * HALF_BASE_US / 1000;
    localparam int unsigned NUM_WAVES     = 7;
    localparam int unsigned TICK_W        = 14;
    // half periods in 5 ms ticks
    localparam logic [TICK_W-1:0] HALF_TICKS [NUM_WAVES] = '{
        TICK_W'(PER_10MS_US  / PER_10MS_US),
        TICK_W'(PER_20MS_US  / PER_10MS_US),
        TICK_W'(PER_100MS_US / PER_10MS_US),
        TICK_W'(PER_200MS_US / PER_10MS_US),
        TICK_W'(PER_1S_US    / PER_10MS_US),
        TICK_W'(PER_2S_US    / PER_10MS_US),
        TICK_W'(PER_1MIN_US  / PER_10MS_US)};
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 16;
    // word offsets: bit n of word 0 is relay 0x10+n, word 1 is 0x20+n
    localparam logic [ADDR_W-1:0] OFS_WORD0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_WORD1 = 4'h1;
    localparam int unsigned B_CONST_HIGH  = 0;
    localparam int unsigned B_CONST_LOW   = 1;
    localparam int unsigned B_SCAN_TOGGLE = 2;
    localparam int unsigned B_FIRST_HIGH  = 3;
    localparam int unsigned B_FIRST_LOW   = 4;
    localparam int unsigned B_STEP_START  = 5;
    localparam int unsigned B_SQUARE0     = 8;
    localparam int unsigned B_RUN_STATE   = 0;
    localparam int unsigned B_MESSAGE     = 6;
    localparam int unsigned B_FORCING     = 9;
    localparam int unsigned B_INT_EN      = 10;
    localparam int unsigned B_INT_FAULT   = 11;
    localparam int unsigned B_SAMPLE_TIME = 12;
    localparam int unsigned B_TRACE_DONE  = 13;
    localparam int unsigned B_STOP_TRIG   = 14;
    localparam int unsigned B_SAMPLING    = 15;

    typedef struct packed {
        logic run_sel;
        logic message_exec;
        logic forcing;
        logic int_enabled;
        logic int_error;
        logic sample_timed;
        logic trace_start;
        logic trace_stop;
        logic stop_trigger;
    } psr_status_t;

    typedef struct packed {
        logic scan_end;
        logic step_boot;
    } psr_scan_t;

    typedef enum logic [1:0] {
        PSR_PROGRAMMING_POSITION     = 2'b00,
        PSR_FIRST    = 2'b01,
        PSR_RUNNING  = 2'b10
    } psr_run_t;
endpackage

// ==== tb_psr_flags.sv ====
// testbench: flag bank compared with a model kept in integers
// assumes psr_pkg and psr_flags are compiled before this file
`timescale 1ns/1ns
module tb_psr_flags;
    // ****************************************************
    // stimulus, results and model state
    // ****************************************************
    localparam int LIMIT = 20000;
    logic                 clk;
    logic                 rst_n;
    psr_pkg::psr_scan_t   scan;
    psr_pkg::psr_status_t st;
    logic [3:0]           addr;
    logic [15:0]          wdata;
    logic                 wr;
    logic                 rd;
    logic [15:0]          rdata;
    logic [15:0]          rdata_s;
    logic                 err;
    logic [15:0]          got;
    logic [15:0]          got_s;
    logic                 got_err;
    logic [15:0]          mask0;
    int fails, tests_run, cycles, seed, r, i;
    int m_run, m_first, m_tog, m_step, m_fault, m_done, m_samp;

    psr_flags #(.HAS_TRACE(1'b1)) uut (.core_clk_in(clk), .rst_n_in(rst_n),
        .scan_in(scan), .status_in(st), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .err_out(err));
    // small variant: trace flags absent
    psr_flags #(.HAS_TRACE(1'b0)) uut_s (.core_clk_in(clk),
        .rst_n_in(rst_n), .scan_in(scan), .status_in(st), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_s),
        .err_out());

    function automatic logic [15:0] exp0();
        logic [15:0] e;
        // constant high and all square waves in their first, on half
        e = 16'h7F01;
        e[2] = m_tog[0];
        e[3] = m_run[0] & m_first[0];
        e[4] = m_run[0] & ~m_first[0];
        e[5] = m_step[0];
        return e;
    endfunction

    function automatic logic [15:0] exp1();
        logic [15:0] e;
        e = 16'h0000;
        e[0] = m_run[0];
        e[6] = st.message_exec;
        e[9] = st.forcing;
        e[10] = st.int_enabled;
        e[11] = m_fault[0];
        e[12] = st.sample_timed;
        e[13] = m_done[0];
        e[14] = st.stop_trigger;
        e[15] = m_samp[0];
        return e;
    endfunction

    task automatic chk16(input string w, input logic [15:0] x,
                         input logic [15:0] s);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", w, x, s);
        end
    endtask

    task automatic chk1(input string w, input logic x, input logic s);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("mismatch %s expected %b seen %b", w, x, s);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one bus cycle, strobe dropped at the answer edge
    task automatic access(input logic w, input logic [3:0] a);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= 16'($random(seed));
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        got = rdata;
        got_s = rdata_s;
        got_err = err;
    endtask

    task automatic check_words();
        access(1'b0, 4'h0);
        chk16("word0", exp0() & mask0, got & mask0);
        access(1'b0, 4'h1);
        chk16("word1", exp1(), got);
        chk16("word1_small", exp1() & 16'h0FFF, got_s);
    endtask

    task automatic scan_end(input logic boot);
        if (boot) begin
            @(posedge clk);
            scan <= 2'b01;
        end
        @(posedge clk);
        scan <= 2'b10;
        @(posedge clk);
        scan <= 2'b00;
        m_tog = m_tog ^ 1;
        m_first = 0;
        m_step = boot;
        idle(2);
    endtask

    // kind: 0 none, 1 start, 2 stop, 3 start and stop, 4 fault
    task automatic pulse(input int k);
        @(posedge clk);
        st.trace_start <= (k == 1 || k == 3);
        st.trace_stop <= (k == 2 || k == 3);
        st.int_error <= (k == 4);
        @(posedge clk);
        st.trace_start <= 1'b0;
        st.trace_stop <= 1'b0;
        st.int_error <= 1'b0;
        if (k == 1 || k == 3) begin
            m_samp = 1;
            m_done = 0;
        end else if (k == 2) begin
            m_samp = 0;
            m_done = 1;
        end
        if (k == 4) m_fault = 1;
        idle(2);
    endtask

    task automatic model_reset();
        {m_run, m_first, m_tog, m_step, m_fault, m_done, m_samp} = '0;
        mask0 = 16'hFFFF;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            fails++;
            $display("mismatch timeout expected %0d seen %0d", LIMIT, cycles);
            wrap_up();
        end
    end

    initial begin
        {fails, tests_run, cycles} = '0;
        seed = 25;
        rst_n = 1'b0;
        scan = '0;
        st = '0;
        {addr, wdata, wr, rd} = '0;
        model_reset();
        idle(4);
        rst_n <= 1'b1;
        pulse(1);
        for (i = 0; i < 16; i++) begin
            access(1'b0, i[3:0]);
            chk16("read", i == 0 ? exp0() : i == 1 ? exp1() : 16'h0, got);
            chk1("read_err", i > 1, got_err);
            access(1'b1, i[3:0]);
            chk16("write_data", 16'h0000, got);
            chk1("write_err", 1'b1, got_err);
        end
        $display("test registers done");
        st.run_sel <= 1'b1;
        m_run = 1;
        m_first = 1;
        idle(3);
        check_words();
        scan_end(1'b0);
        check_words();
        scan_end(1'b1);
        check_words();
        scan_end(1'b0);
        check_words();
        @(posedge clk);
        wr <= 1'b1;
        addr <= 4'h0;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        #1 chk1("b2b_write_err", 1'b1, err);
        @(posedge clk);
        rd <= 1'b0;
        #1 chk16("b2b_read", exp0(), rdata);
        @(posedge clk);
        #1 chk16("read_gone", 16'h0000, rdata);
        st.run_sel <= 1'b0;
        m_run = 0;
        mask0 = 16'hFFDB;
        idle(3);
        check_words();
        st.run_sel <= 1'b1;
        m_run = 1;
        m_first = 1;
        idle(3);
        check_words();
        scan_end(1'b0);
        check_words();
        $display("test scans done");
        for (i = 0; i < 14; i++) begin
            r = $random(seed);
            st.message_exec <= r[0];
            st.forcing <= r[1];
            st.int_enabled <= r[2];
            st.sample_timed <= r[3];
            st.stop_trigger <= r[4];
            pulse(i < 5 ? i : int'(r[7:5]) % 5);
            check_words();
        end
        $display("test status done");
        @(posedge clk);
        rst_n <= 1'b0;
        st <= '0;
        idle(2);
        #1 chk16("reset_rdata", 16'h0000, rdata);
        model_reset();
        rst_n <= 1'b1;
        pulse(2);
        check_words();
        $display("test second reset done");
        wrap_up();
    end
endmodule
